// ### rtl/iolpt_consts.svh
// Purpose: Offsets, field positions, codes, reset values and timing counts of the I/O line trigger block.
// Assumes: Included by every file of the block that needs a number.
// Notes: Definitions only.
`ifndef IOLPT_CONSTS_SVH
`define IOLPT_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IOLPT_CLK_MHZ 40
`define IOLPT_TICK_US 120

// ----------------------------------------------------------------
// Command codes and their lengths in words, code word included
// ----------------------------------------------------------------
`define IOLPT_CMD_CFG 8'hBC
`define IOLPT_CMD_CLR 8'hCE
`define IOLPT_CMD_SET 8'hCD
`define IOLPT_CMD_CMP 8'hF5
`define IOLPT_CMD_TBL 8'h4E
`define IOLPT_WORDS_CFG 4'h3
`define IOLPT_WORDS_CLR 4'h2
`define IOLPT_WORDS_SET 4'h2
`define IOLPT_WORDS_CMP 4'h2
`define IOLPT_WORDS_TBL 4'h5

// ----------------------------------------------------------------
// Line mode codes, 16-bit two's complement
// ----------------------------------------------------------------
`define IOLPT_MODE_INPUT 16'hFFFF
`define IOLPT_MODE_LOW 16'h0000
`define IOLPT_MODE_HIGH 16'h0001
`define IOLPT_MODE_PULL_UP 16'hFFFE
`define IOLPT_MODE_PULL_DN 16'hFFFD
`define IOLPT_MODE_PULL_OFF 16'hFFFC
`define IOLPT_EXT_FIRST 16'h0065
`define IOLPT_EXT_LAST 16'h0074

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IOLPT_OFF_CODE 12'h000
`define IOLPT_OFF_ARG0 12'h004
`define IOLPT_OFF_ARG1 12'h008
`define IOLPT_OFF_ARG2 12'h00C
`define IOLPT_OFF_ARG3 12'h010
`define IOLPT_OFF_GO 12'h014
`define IOLPT_OFF_LINE_IN 12'h018
`define IOLPT_OFF_FAULT 12'h01C
`define IOLPT_OFF_DIR 12'h020
`define IOLPT_OFF_POS 12'h024
`define IOLPT_OFF_STATUS 12'h028
`define IOLPT_OFF_USER_PAGE 4'h1

// ----------------------------------------------------------------
// Status fields and reset values
// ----------------------------------------------------------------
`define IOLPT_ST_CMP_BIT 0
`define IOLPT_ST_TBL_BIT 1
`define IOLPT_ST_ERR_BIT 2
`define IOLPT_RST_WORD 32'h0000_0000

`endif

// ### rtl/iolpt_pkg.sv
// Purpose: Types shared by the I/O line trigger block.
// Assumes: Numbers live in iolpt_consts.svh.
// Notes: Enumerations leave their codes to the tools.
package iolpt_pkg;
	typedef enum logic [2:0] {CMD_NONE, CMD_CFG, CMD_CLR, CMD_SET, CMD_CMP, CMD_TBL} iolpt_cmd_e;
	typedef enum logic [1:0] {TBL_IDLE, TBL_POINTS, TBL_MODULO} iolpt_tbl_e;
	typedef logic signed [31:0] iolpt_pos_t;
	typedef logic [31:0] iolpt_word_t;
endpackage

// ### rtl/iolpt_reg_if.sv
// Purpose: Simple register access between the bus slave and the register file.
// Assumes: Read address is combinational, write strobe is one cycle.
// Notes: Read data must be valid in the cycle the address is shown.
`timescale 1ns/10ps
interface iolpt_reg_if;
	logic [11:0] rd_addr;
	logic [31:0] rd_data;
	logic wr_en;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	modport bus (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
	modport regs (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

// ### rtl/iolpt_ahb_slv.sv
// Purpose: AHB-Lite slave front end with no wait states.
// Assumes: Single word transfers; one slave on the bus.
// Notes: Read data is captured at the address phase edge, so a read right after a write to the same
// register returns the value before that write.
`timescale 1ns/10ps
`include "iolpt_consts.svh"
module iolpt_ahb_slv
	import iolpt_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	iolpt_reg_if.bus rb
);
	// ----------------------------------------------------------------
	// Address phase decode
	// ----------------------------------------------------------------
	logic wph_q;
	logic [11:0] waddr_q;
	logic [31:0] hrdata_q;
	logic hready_q;
	wire take = hsel && htrans[1] && hready;
	wire size_ok = (hsize == 3'h2);

	// Register side sees the live address for reads, the held one for writes.
	assign rb.rd_addr = haddr[11:0];
	assign rb.wr_en = wph_q;
	assign rb.wr_addr = waddr_q;
	assign rb.wr_data = hwdata;
	assign hrdata = hrdata_q;
	assign hreadyout = hready_q;
	assign hresp = 1'b0;

	// Capture the address phase; read data is ready by the data phase.
	always_ff @(posedge mclk) begin
		if (srst) begin
			wph_q <= 1'b0;
			waddr_q <= 12'h000;
			hrdata_q <= `IOLPT_RST_WORD;
			hready_q <= 1'b1;
		end else begin
			wph_q <= take && hwrite && size_ok;
			waddr_q <= haddr[11:0];
			if (take && !hwrite) begin
				hrdata_q <= rb.rd_data;
			end
		end
	end
endmodule

// ### rtl/iolpt_top.sv
// Purpose: Digital I/O lines with mode commands and two position trigger engines.
// Assumes: Position and pin inputs are synchronous to mclk; commands arrive by register writes.
// Notes: Both trigger engines act only on the periodic tick.
// Summary of operation
// [R1] Mode -1 input, 0 drive low, 1 drive high.
// [R2] All lines start as inputs after reset.
// [R3] Extended lines 101-116 drive low only.
// [R4] Extended lines read back pin while driven.
// [R5] Host waits out input filter before judging faults.
// [R6] Codes -2, -3, -4 set pull up, down, off.
// [R7] Host sets pulls only on input lines.
// [R8] Configure command 188, three words, one line.
// [R9] Clear command 206 forces line to output low.
// [R10] Compare toggles line 1 on each crossing.
// [R11] Crossing up adds modulo, down subtracts it.
// [R12] Zero modulo keeps trigger position fixed.
// [R13] Trigger in named register, modulo in next.
// [R14] Host sets line 1 output before compare.
// [R15] Compare evaluated once per periodic tick.
// [R16] Compare runs until command 245 with register 0.
// [R17] Table command 78, five words, line 0 disables.
// [R18] Each tick compare table point, toggle on reach.
// [R19] Table restarts after each modulo position passed.
// [R20] Positions and compares are signed 32-bit.
`timescale 1ns/10ps
`include "iolpt_consts.svh"
module iolpt_top
	import iolpt_pkg::*;
#(
	parameter int NUM_LINES = 16,
	parameter int USER_REGS = 32,
	parameter int PULL_CAPABLE = 1,
	parameter int TICK_CYCLES = `IOLPT_TICK_US * `IOLPT_CLK_MHZ
)(
	input wire logic mclk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic signed [31:0] position,
	input wire logic [NUM_LINES-1:0] line_in,
	output logic [NUM_LINES-1:0] line_out,
	output logic [NUM_LINES-1:0] line_oe,
	output logic [NUM_LINES-1:0] line_pull_up,
	output logic [NUM_LINES-1:0] line_pull_dn,
	input wire logic [15:0] ext_in,
	output logic [15:0] ext_oe
);
	localparam int LW = $clog2(NUM_LINES);
	localparam int UW = $clog2(USER_REGS);
	localparam int TW = $clog2(TICK_CYCLES);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

	// ----------------------------------------------------------------
	// Line decoding helpers
	// ----------------------------------------------------------------
	function automatic logic is_norm(input logic [15:0] ln);
		return (ln >= 16'h0001) && (ln <= 16'(NUM_LINES));
	endfunction

	function automatic logic is_ext(input logic [15:0] ln);
		return (ln >= `IOLPT_EXT_FIRST) && (ln <= `IOLPT_EXT_LAST);
	endfunction

	// ----------------------------------------------------------------
	// Bus front end
	// ----------------------------------------------------------------
	iolpt_reg_if rb ();
	iolpt_ahb_slv u_slv (
		.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .rb(rb)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] code_q;
	logic [31:0] arg0_q, arg1_q, arg2_q, arg3_q;
	logic [NUM_LINES-1:0] line_out_q, line_oe_q, pull_up_q, pull_dn_q;
	logic [15:0] ext_oe_q, fault_q;
	iolpt_pos_t user_q [USER_REGS];
	logic [TW-1:0] tick_cnt_q;
	logic tick_q;
	logic cmp_en_q;
	logic [UW-1:0] cmp_reg_q;
	iolpt_pos_t prev_pos_q;
	iolpt_tbl_e tbl_q;
	logic [LW-1:0] tbl_line_q;
	logic tbl_init_q;
	logic [UW-1:0] tbl_start_q, tbl_k_q, tbl_cnt_q;
	iolpt_pos_t tbl_base_q;
	logic err_q;
	logic [3:0] words_q;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	wire go = rb.wr_en && (rb.wr_addr == `IOLPT_OFF_GO);
	wire [15:0] ln = arg0_q[15:0];
	wire [15:0] mode = arg1_q[15:0];
	wire ln_norm = is_norm(ln);
	wire ln_ext = is_ext(ln);
	wire [LW-1:0] nidx = LW'(ln - 16'h0001);
	wire [3:0] eidx = 4'(ln - `IOLPT_EXT_FIRST);
	wire pulls_on = (PULL_CAPABLE != 0);
	iolpt_cmd_e cmd_kind;
	logic [3:0] cmd_words;
	always_comb begin
		case (code_q)
			`IOLPT_CMD_CFG: begin cmd_kind = CMD_CFG; cmd_words = `IOLPT_WORDS_CFG; end // [R8]
			`IOLPT_CMD_CLR: begin cmd_kind = CMD_CLR; cmd_words = `IOLPT_WORDS_CLR; end
			`IOLPT_CMD_SET: begin cmd_kind = CMD_SET; cmd_words = `IOLPT_WORDS_SET; end
			`IOLPT_CMD_CMP: begin cmd_kind = CMD_CMP; cmd_words = `IOLPT_WORDS_CMP; end
			`IOLPT_CMD_TBL: begin cmd_kind = CMD_TBL; cmd_words = `IOLPT_WORDS_TBL; end // [R17]
			default: begin cmd_kind = CMD_NONE; cmd_words = 4'h0; end
		endcase
	end

	// Register numbers for the trigger engines must leave room for the following word.
	wire cmp_off = (arg0_q == 32'h0); // [R16]
	wire cmp_ok = arg0_q < 32'(USER_REGS - 1);
	wire tbl_off = (ln == 16'h0000); // [R17]
	wire [31:0] tbl_last = arg2_q + arg3_q;
	wire tbl_ok = ln_norm && (arg3_q != 32'h0) && (tbl_last < 32'(USER_REGS)) && (arg1_q <= 32'h1);
	wire line_cmd = (cmd_kind == CMD_CFG) || (cmd_kind == CMD_CLR) || (cmd_kind == CMD_SET);
	wire bad_cmd = (cmd_kind == CMD_NONE) || (line_cmd && !ln_norm && !ln_ext) ||
		((cmd_kind == CMD_CMP) && !cmp_off && !cmp_ok) || ((cmd_kind == CMD_TBL) && !tbl_off && !tbl_ok);

	// ----------------------------------------------------------------
	// Periodic tick divider
	// ----------------------------------------------------------------
	// One enable pulse per tick period; both engines compare position only then.
	always_ff @(posedge mclk) begin
		if (srst) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == TICK_LAST);
			tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Single-point compare engine
	// ----------------------------------------------------------------
	wire [UW-1:0] cmp_mod_reg = cmp_reg_q + 1'b1;
	wire iolpt_pos_t cmp_trig = user_q[cmp_reg_q]; // [R13]
	wire iolpt_pos_t cmp_mod = user_q[cmp_mod_reg]; // [R13]
	// Signed compares so that negative encoder counts order correctly.
	wire cmp_up = tick_q && cmp_en_q && (prev_pos_q < cmp_trig) && (position >= cmp_trig); // [R20] [R15]
	wire cmp_dn = tick_q && cmp_en_q && (prev_pos_q >= cmp_trig) && (position < cmp_trig); // [R20] [R15]
	wire cmp_cross = cmp_up || cmp_dn;
	wire cmp_step = cmp_cross && (cmp_mod != 32'sh0); // [R12]
	wire iolpt_pos_t cmp_next = cmp_up ? cmp_trig + cmp_mod : cmp_trig - cmp_mod; // [R11]

	// Enable state and the previous sampled position.
	always_ff @(posedge mclk) begin
		if (srst) begin
			cmp_en_q <= 1'b0;
			cmp_reg_q <= '0;
			prev_pos_q <= 32'sh0;
		end else begin
			if (tick_q) begin
				prev_pos_q <= position;
			end
			if (go && (cmd_kind == CMD_CMP)) begin
				if (cmp_off) begin
					cmp_en_q <= 1'b0; // [R16]
				end else if (cmp_ok) begin
					cmp_en_q <= 1'b1;
					cmp_reg_q <= UW'(arg0_q);
					prev_pos_q <= position;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Trigger table engine
	// ----------------------------------------------------------------
	wire [UW-1:0] tbl_ptr = tbl_start_q + tbl_k_q;
	wire [UW-1:0] tbl_mod_reg = tbl_start_q + tbl_cnt_q;
	wire iolpt_pos_t tbl_rel = position - tbl_base_q; // [R20]
	wire iolpt_pos_t tbl_point = user_q[tbl_ptr];
	wire iolpt_pos_t tbl_mod = user_q[tbl_mod_reg];
	wire tbl_hit = tick_q && (tbl_q == TBL_POINTS) && (tbl_rel >= tbl_point); // [R18]
	wire tbl_wrap = tick_q && (tbl_q == TBL_MODULO) && (tbl_rel >= tbl_mod); // [R19]
	wire tbl_last_hit = tbl_hit && (tbl_k_q == tbl_cnt_q - 1'b1);

	// Points are walked in order; the word after the last point is the cycle length.
	always_ff @(posedge mclk) begin
		if (srst) begin
			tbl_q <= TBL_IDLE;
			tbl_line_q <= '0;
			tbl_init_q <= 1'b0;
			tbl_start_q <= '0;
			tbl_cnt_q <= '0;
			tbl_k_q <= '0;
			tbl_base_q <= 32'sh0;
		end else if (go && (cmd_kind == CMD_TBL) && (tbl_off || tbl_ok)) begin
			tbl_q <= tbl_off ? TBL_IDLE : TBL_POINTS; // [R17]
			tbl_line_q <= nidx;
			tbl_init_q <= arg1_q[0];
			tbl_start_q <= UW'(arg2_q);
			tbl_cnt_q <= UW'(arg3_q);
			tbl_k_q <= '0;
			tbl_base_q <= position;
		end else begin
			case (tbl_q)
				TBL_IDLE: begin
					tbl_k_q <= '0;
				end
				TBL_POINTS: begin
					if (tbl_last_hit) begin
						tbl_q <= TBL_MODULO;
					end else if (tbl_hit) begin
						tbl_k_q <= tbl_k_q + 1'b1;
					end
				end
				TBL_MODULO: begin
					if (tbl_wrap) begin
						tbl_q <= TBL_POINTS; // [R19]
						tbl_k_q <= '0;
						tbl_base_q <= tbl_base_q + tbl_mod;
					end
				end
				default: begin
					tbl_q <= TBL_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Line drivers
	// ----------------------------------------------------------------
	// Commands first, engine toggles last so a tick never loses its edge.
	always_ff @(posedge mclk) begin
		if (srst) begin
			line_out_q <= '0;
			line_oe_q <= '0; // [R2]
			pull_up_q <= '0;
			pull_dn_q <= '0;
			ext_oe_q <= '0; // [R2]
		end else begin
			if (go && ln_norm) begin
				case (cmd_kind)
					CMD_CFG: begin
						case (mode)
							`IOLPT_MODE_INPUT: line_oe_q[nidx] <= 1'b0; // [R1]
							`IOLPT_MODE_LOW: begin line_oe_q[nidx] <= 1'b1; line_out_q[nidx] <= 1'b0; end // [R1]
							`IOLPT_MODE_HIGH: begin line_oe_q[nidx] <= 1'b1; line_out_q[nidx] <= 1'b1; end // [R1]
							`IOLPT_MODE_PULL_UP: if (pulls_on) begin
								pull_up_q[nidx] <= 1'b1; // [R6]
								pull_dn_q[nidx] <= 1'b0;
							end
							`IOLPT_MODE_PULL_DN: if (pulls_on) begin
								pull_up_q[nidx] <= 1'b0; // [R6]
								pull_dn_q[nidx] <= 1'b1;
							end
							`IOLPT_MODE_PULL_OFF: if (pulls_on) begin
								pull_up_q[nidx] <= 1'b0; // [R6]
								pull_dn_q[nidx] <= 1'b0;
							end
							default: line_oe_q[nidx] <= line_oe_q[nidx];
						endcase
					end
					CMD_CLR: begin line_oe_q[nidx] <= 1'b1; line_out_q[nidx] <= 1'b0; end // [R9]
					CMD_SET: begin line_oe_q[nidx] <= 1'b1; line_out_q[nidx] <= 1'b1; end
					CMD_TBL: if (tbl_ok) begin
						line_oe_q[nidx] <= 1'b1;
						line_out_q[nidx] <= arg1_q[0];
					end
					default: line_oe_q[nidx] <= line_oe_q[nidx];
				endcase
			end
			// Open-collector lines can only sink; high and input both release the driver.
			if (go && ln_ext) begin
				case (cmd_kind)
					CMD_CFG: begin
						if (mode == `IOLPT_MODE_LOW) begin
							ext_oe_q[eidx] <= 1'b1; // [R3]
						end else if ((mode == `IOLPT_MODE_INPUT) || (mode == `IOLPT_MODE_HIGH)) begin
							ext_oe_q[eidx] <= 1'b0; // [R3]
						end
					end
					CMD_CLR: ext_oe_q[eidx] <= 1'b1; // [R9]
					CMD_SET: ext_oe_q[eidx] <= 1'b0;
					default: ext_oe_q[eidx] <= ext_oe_q[eidx];
				endcase
			end
			// Line 1 is driven by the compare engine; the host must have made it an output.
			if (cmp_cross) begin
				line_out_q[0] <= ~line_out_q[0]; // [R10] [R14]
			end
			if (tbl_hit) begin
				line_out_q[tbl_line_q] <= ~line_out_q[tbl_line_q]; // [R18]
			end else if (tbl_wrap) begin
				line_out_q[tbl_line_q] <= tbl_init_q; // [R19]
			end
		end
	end

	// Fault shows a sunk line whose pin still reads high; the pin filter delay is the host's concern.
	always_ff @(posedge mclk) begin
		if (srst) begin
			fault_q <= '0;
		end else begin
			fault_q <= ext_oe_q & ext_in; // [R4] [R5]
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	wire user_wr = rb.wr_en && (rb.wr_addr[11:8] == `IOLPT_OFF_USER_PAGE) && (rb.wr_addr[7:2] < 6'(USER_REGS));
	wire [UW-1:0] user_widx = UW'(rb.wr_addr[7:2]);

	// Bus writes first; the compare write-back wins in the rare shared cycle.
	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int i = 0; i < USER_REGS; i++) begin
				user_q[i] <= 32'sh0;
			end
		end else begin
			if (user_wr) begin
				user_q[user_widx] <= rb.wr_data;
			end
			if (cmp_step) begin
				user_q[cmp_reg_q] <= cmp_next; // [R11] [R12]
			end
		end
	end

	// Command words and status.
	always_ff @(posedge mclk) begin
		if (srst) begin
			code_q <= 8'h00;
			arg0_q <= `IOLPT_RST_WORD;
			arg1_q <= `IOLPT_RST_WORD;
			arg2_q <= `IOLPT_RST_WORD;
			arg3_q <= `IOLPT_RST_WORD;
			err_q <= 1'b0;
			words_q <= 4'h0;
		end else begin
			if (rb.wr_en && (rb.wr_addr == `IOLPT_OFF_CODE)) code_q <= rb.wr_data[7:0];
			if (rb.wr_en && (rb.wr_addr == `IOLPT_OFF_ARG0)) arg0_q <= rb.wr_data;
			if (rb.wr_en && (rb.wr_addr == `IOLPT_OFF_ARG1)) arg1_q <= rb.wr_data;
			if (rb.wr_en && (rb.wr_addr == `IOLPT_OFF_ARG2)) arg2_q <= rb.wr_data;
			if (rb.wr_en && (rb.wr_addr == `IOLPT_OFF_ARG3)) arg3_q <= rb.wr_data;
			if (go) begin
				err_q <= bad_cmd;
				words_q <= cmd_words;
			end
		end
	end

	// Read multiplexer; unmapped addresses read zero.
	wire user_rd = (rb.rd_addr[11:8] == `IOLPT_OFF_USER_PAGE) && (rb.rd_addr[7:2] < 6'(USER_REGS));
	wire [31:0] status_word = {24'h0, words_q, 1'b0, err_q, (tbl_q != TBL_IDLE), cmp_en_q};
	wire [31:0] in_word = {ext_in, 16'(line_in)};
	wire [31:0] dir_word = {ext_oe_q, 16'(line_oe_q)};
	assign rb.rd_data = user_rd ? user_q[UW'(rb.rd_addr[7:2])] :
		(rb.rd_addr == `IOLPT_OFF_CODE) ? {24'h0, code_q} :
		(rb.rd_addr == `IOLPT_OFF_ARG0) ? arg0_q :
		(rb.rd_addr == `IOLPT_OFF_ARG1) ? arg1_q :
		(rb.rd_addr == `IOLPT_OFF_ARG2) ? arg2_q :
		(rb.rd_addr == `IOLPT_OFF_ARG3) ? arg3_q :
		(rb.rd_addr == `IOLPT_OFF_LINE_IN) ? in_word :
		(rb.rd_addr == `IOLPT_OFF_FAULT) ? {16'h0, fault_q} :
		(rb.rd_addr == `IOLPT_OFF_DIR) ? dir_word :
		(rb.rd_addr == `IOLPT_OFF_POS) ? position :
		(rb.rd_addr == `IOLPT_OFF_STATUS) ? status_word : 32'h0;

	assign line_out = line_out_q;
	assign line_oe = line_oe_q;
	assign line_pull_up = pull_up_q;
	assign line_pull_dn = pull_dn_q;
	assign ext_oe = ext_oe_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	sequence s_line_cmd(iolpt_cmd_e k);
		go && (cmd_kind == k) && ln_norm && !tick_q;
	endsequence
	sequence s_cfg_mode(logic [15:0] m);
		s_line_cmd(CMD_CFG) ##0 (mode == m);
	endsequence

	// Pull codes leave an open-collector driver alone, so only the three drive modes are judged.
	wire ext_drv_mode = (mode <= `IOLPT_MODE_HIGH) || (mode == `IOLPT_MODE_INPUT);

	a_reset_inputs: assert property (disable iff (1'b0) srst |=> (line_oe == '0) && (ext_oe == '0)) // [R2]
		else $error("lines not inputs after reset");
	a_mode_high: assert property (s_cfg_mode(`IOLPT_MODE_HIGH) |=> line_oe[$past(nidx)] && line_out[$past(nidx)]) // [R1]
		else $error("mode 1 did not drive high");
	a_mode_input: assert property (s_cfg_mode(`IOLPT_MODE_INPUT) |=> !line_oe[$past(nidx)]) // [R1]
		else $error("mode -1 did not release line");
	a_ext_sink: assert property (go && (cmd_kind == CMD_CFG) && ln_ext && ext_drv_mode // [R3]
		|=> ext_oe[$past(eidx)] == ($past(mode) == `IOLPT_MODE_LOW))
		else $error("extended line drive wrong");
	a_ext_fault: assert property (##1 fault_q == $past(ext_oe_q & ext_in)) // [R4]
		else $error("fault readback wrong");
	a_pull_up: assert property (s_cfg_mode(`IOLPT_MODE_PULL_UP) ##0 pulls_on |=> line_pull_up[$past(nidx)] && !line_pull_dn[$past(nidx)]) // [R6]
		else $error("pull-up not applied");
	a_clear_out: assert property (s_line_cmd(CMD_CLR) |=> line_oe[$past(nidx)] && !line_out[$past(nidx)]) // [R9]
		else $error("clear did not drive low");
	a_cmp_toggle: assert property (cmp_cross && !go |=> line_out[0] != $past(line_out_q[0])) // [R10]
		else $error("compare crossing did not toggle line 1");
	a_cmp_step: assert property (cmp_up && !go |=> user_q[$past(cmp_reg_q)] == $past(cmp_trig + cmp_mod)) // [R11]
		else $error("trigger not advanced by modulo");
	a_cmp_fixed: assert property (cmp_cross && (cmp_mod == 32'sh0) && !user_wr |=> $stable(user_q[cmp_reg_q])) // [R12]
		else $error("zero modulo changed trigger");
	a_cmp_tick: assert property (!tick_q && !go |=> $stable(line_out_q)) // [R15]
		else $error("line changed between ticks");
	a_cmp_stop: assert property (go && (cmd_kind == CMD_CMP) && cmp_off |=> !cmp_en_q ##1 !cmp_cross) // [R16]
		else $error("compare not stopped");
	a_tbl_hit: assert property (tbl_hit && !go |=> line_out[$past(tbl_line_q)] != $past(line_out_q[tbl_line_q])) // [R18]
		else $error("table point did not toggle");
	a_tbl_wrap: assert property (tbl_wrap && !go |=> (tbl_q == TBL_POINTS) && (tbl_k_q == '0)) // [R19]
		else $error("table did not restart");
endmodule

// ### dv/iolpt_load.sv
// Purpose: Model of the loads and sensors on the I/O pins.
// Assumes: Pins settle within the cycle.
// Notes: A floating line without pull reads the inverse of its output value.
`timescale 1ns/10ps
module iolpt_load (
	input wire logic [15:0] line_out,
	input wire logic [15:0] line_oe,
	input wire logic [15:0] line_pull_up,
	input wire logic [15:0] line_pull_dn,
	input wire logic [15:0] ext_oe,
	input wire logic [15:0] ext_trip,
	output logic [15:0] line_in,
	output logic [15:0] ext_in
);
	// Undriven lines follow their pull, else the inverse, so stale levels never pass.
	assign line_in = (line_oe & line_out) | (~line_oe & (line_pull_up | (~line_pull_dn & ~line_out)));
	// Open collector with pull-up; a tripped driver lets the pin float high.
	assign ext_in = ~ext_oe | ext_trip;
endmodule

// ### dv/io_line_position_trigger_test.sv
// Purpose: Self-checking bench for the I/O line trigger block.
// Assumes: Short tick of 16 cycles.
// Notes: Waits of 40 cycles cover two ticks.
`timescale 1ns/10ps
module io_line_position_trigger_test;
	import iolpt_pkg::*;
	logic mclk = 0, srst = 1, hwrite = 0, hready, hresp;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	iolpt_pos_t position = 32'h0;
	logic [15:0] line_in, line_out, line_oe, pu, pd, ext_in, ext_oe, trip = 16'h0;
	int error_cnt = 0, comparisons = 0, cyc = 0;
	logic [15:0] md[6] = '{16'h0000, 16'h0001, 16'hFFFF, 16'hFFFE, 16'hFFFD, 16'hFFFC};
	logic [3:0] ex[6] = '{4'h8, 4'hC, 4'h0, 4'h2, 4'h1, 4'h0};
	always #12.5 mclk = ~mclk;
	iolpt_top #(.TICK_CYCLES(16)) dut (.mclk(mclk), .srst(srst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready),
		.hresp(hresp), .position(position), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
		.line_pull_up(pu), .line_pull_dn(pd), .ext_in(ext_in), .ext_oe(ext_oe));
	iolpt_load load (.line_out(line_out), .line_oe(line_oe), .line_pull_up(pu), .line_pull_dn(pd),
		.ext_oe(ext_oe), .ext_trip(trip), .line_in(line_in), .ext_in(ext_in));
	// ----------------------------------------------------------------
	// Bus and check helpers
	// ----------------------------------------------------------------
	task close_out;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	// One transfer; the master never assumes a latency, it waits for hready.
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		r = hrdata;
		chk("resp", 32'h0, hresp);
	endtask
	task cmd(input logic [31:0] c, a0, a1, a2, a3);
		logic [31:0] v[5];
		v = '{c, a0, a1, a2, a3};
		for (int i = 0; i < 5; i++) xfer(1'b1, 12'(4 * i), v[i]);
		xfer(1'b1, 12'h014, 32'h1);
		repeat (2) @(posedge mclk);
	endtask
	// Hang guard sized well above the expected run length.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end
	// Main sequence.
	initial begin
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		xfer(1'b0, 12'h020, 32'h0);
		chk("dir", 32'h0, r);
		for (int i = 0; i < 6; i++) begin
			cmd(32'hBC, 32'h3, {{16{md[i][15]}}, md[i]}, 32'h0, 32'h0);
			chk("line3", ex[i], {line_oe[2], line_out[2] & line_oe[2], pu[2], pd[2]});
		end
		$display("modes done");
		cmd(32'hBC, 32'h65, 32'h0, 32'h0, 32'h0);
		chk("ext oe", 32'h1, ext_oe);
		trip <= 16'h1;
		repeat (8) @(posedge mclk);
		xfer(1'b0, 12'h01C, 32'h0);
		chk("fault", 32'h1, r[15:0]);
		trip <= 16'h0;
		cmd(32'hBC, 32'h65, 32'h1, 32'h0, 32'h0);
		chk("ext off", 32'h0, ext_oe);
		cmd(32'hCD, 32'h5, 32'h0, 32'h0, 32'h0);
		chk("line5 set", 32'h3, {line_oe[4], line_out[4]});
		cmd(32'hBC, 32'h5, 32'hFFFF_FFFF, 32'h0, 32'h0);
		cmd(32'hCE, 32'h5, 32'h0, 32'h0, 32'h0);
		chk("line5", 32'h2, {line_oe[4], line_out[4]});
		$display("extended and clear done");
		xfer(1'b1, 12'h104, 32'hFFFF_FF9C);
		xfer(1'b1, 12'h108, 32'h32);
		position <= 32'hFFFF_FF38;
		cmd(32'hBC, 32'h1, 32'h0, 32'h0, 32'h0);
		cmd(32'hF5, 32'h1, 32'h0, 32'h0, 32'h0);
		repeat (40) @(posedge mclk);
		position <= 32'h0;
		repeat (40) @(posedge mclk);
		chk("up toggle", 32'h1, line_out[0]);
		xfer(1'b0, 12'h104, 32'h0);
		chk("trig up", 32'hFFFF_FFCE, r);
		position <= 32'hFFFF_FFC4;
		repeat (40) @(posedge mclk);
		chk("down toggle", 32'h0, line_out[0]);
		xfer(1'b0, 12'h104, 32'h0);
		chk("trig down", 32'hFFFF_FF9C, r);
		xfer(1'b1, 12'h108, 32'h0);
		position <= 32'hFFFF_FF38;
		repeat (40) @(posedge mclk);
		chk("fixed toggle", 32'h1, line_out[0]);
		xfer(1'b0, 12'h104, 32'h0);
		chk("trig fixed", 32'hFFFF_FF9C, r);
		cmd(32'hF5, 32'h0, 32'h0, 32'h0, 32'h0);
		position <= 32'h0;
		repeat (40) @(posedge mclk);
		chk("cmp off", 32'h1, line_out[0]);
		$display("compare done");
		xfer(1'b1, 12'h128, 32'h14);
		xfer(1'b1, 12'h12C, 32'h64);
		cmd(32'h4E, 32'h4, 32'h1, 32'hA, 32'h1);
		chk("tbl init", 32'h3, {line_oe[3], line_out[3]});
		position <= 32'h1E;
		repeat (40) @(posedge mclk);
		chk("tbl point", 32'h0, line_out[3]);
		position <= 32'h69;
		repeat (40) @(posedge mclk);
		chk("tbl wrap", 32'h1, line_out[3]);
		cmd(32'h4E, 32'h0, 32'h0, 32'h0, 32'h0);
		xfer(1'b0, 12'h028, 32'h0);
		chk("tbl off", 32'h0, r[1]);
		chk("tbl words", 32'h5, r[7:4]);
		$display("table done");
		close_out();
	end
endmodule
